// ==== design/ocst_stages.sv ====
// overcurrent stage timers with avalon register slave and interrupt
`timescale 1ns/100ps
// How it works
// - three phase and three earth stages
// - third stages definite delay only
// - inverse only phase1, phase2, earth1
// - trip: over threshold, delay elapsed, unblocked
// - phase over is OR of phases
// - single phase select uses that phase
// - earth stages share same stage logic
// - blocking freezes the stage timer
// - release resumes from held count
// - start output when timer starts
// - overcurrent recognised well inside 20 ms
// - reset timer on phase1, earth1, earth2
// - inverse delay from current and multiplier
// - curve selector offers listed curves
// - clear after below 95% hold time
// - tripped stage resets timer immediately
// - reset type 0 definite, 1 inverse
module ocst_stages
   import ocst_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)(
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   // current magnitudes and blocking
   input  wire logic [15:0] PHASE_A_MAG,
   input  wire logic [15:0] PHASE_B_MAG,
   input  wire logic [15:0] PHASE_C_MAG,
   input  wire logic [15:0] EARTH_MAG,
   input  wire logic [5:0]  BLOCK,
   // stage outputs
   output logic [5:0]       START,
   output logic [5:0]       TRIP,
   output logic             IRQ,
   // avalon slave
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST
);
   function automatic logic ge_thr(input logic [15:0] m, input logic [15:0] t);
      return m > t;
   endfunction
   function automatic logic below95(input logic [15:0] m, input logic [15:0] t);
      return (21'(m) * 21'(PCT_DEN)) < (21'(t) * 21'(PCT_NUM));
   endfunction

   ocst_stage_t stg [NSTG];
   logic [1:0]  ctrl;
   logic [11:0] ist;
   logic [11:0] ien;
   logic [31:0] cnt [NSTG];
   logic [15:0] hcnt [NSTG];
   logic [5:0]  run;
   logic [5:0]  over;
   logic [5:0]  under;
   logic [5:0]  eff_inv;
   logic [31:0] target [NSTG];
   logic [31:0] step [NSTG];
   logic [15:0] mag [NSTG];
   logic [16:0] tick_cnt;
   logic        tick;
   logic        rd_ack;
   logic [5:0]  trip_q;
   logic [5:0]  start_q;
   logic [5:0]  trip_prev;
   logic [11:0] int_clr;

   // 1 ms tick
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         tick_cnt <= 17'h0;
      else if (tick)
         tick_cnt <= 17'h0;
      else
         tick_cnt <= tick_cnt + 17'h1;
   end
   assign tick = (tick_cnt == 17'(TICK_CYCLES - 1));

   // comparisons per stage
   always_comb
   begin
      logic [2:0] ge;
      logic [2:0] lo;
      ge = 3'h0;
      lo = 3'h0;
      for (int s = 0; s < NSTG; s++)
      begin
         ge = {ge_thr(PHASE_C_MAG, stg[s].thr), ge_thr(PHASE_B_MAG, stg[s].thr),
               ge_thr(PHASE_A_MAG, stg[s].thr)};
         lo = {below95(PHASE_C_MAG, stg[s].thr), below95(PHASE_B_MAG, stg[s].thr),
               below95(PHASE_A_MAG, stg[s].thr)};
         // three phase and three earth stages
         if (s < NPH)
         begin
            if (stg[s].cfg.psel == PSEL_ALL)
            begin
               over[s]  = |ge;
               under[s] = &lo;
               mag[s]   = (PHASE_A_MAG > PHASE_B_MAG) ?
                          ((PHASE_A_MAG > PHASE_C_MAG) ? PHASE_A_MAG : PHASE_C_MAG) :
                          ((PHASE_B_MAG > PHASE_C_MAG) ? PHASE_B_MAG : PHASE_C_MAG);
            end
            else
            begin
               over[s]  = ge[stg[s].cfg.psel - 2'h1];
               under[s] = lo[stg[s].cfg.psel - 2'h1];
               case (stg[s].cfg.psel)
                  2'h1:    mag[s] = PHASE_A_MAG;
                  2'h2:    mag[s] = PHASE_B_MAG;
                  default: mag[s] = PHASE_C_MAG;
               endcase
            end
         end
         else
         begin
            over[s]  = ge_thr(EARTH_MAG, stg[s].thr);
            under[s] = below95(EARTH_MAG, stg[s].thr);
            mag[s]   = EARTH_MAG;
         end
         eff_inv[s] = stg[s].cfg.inverse_delay & INV_OK_MASK[s];
         if (eff_inv[s])
         begin
            // us and ieee curves use the dial
            if (stg[s].cfg.curve >= CRV_IEEE_MI && stg[s].cfg.curve <= CRV_CO11)
               target[s] = (32'(stg[s].cfg.time_dial_us) * 32'(stg[s].thr)) << INV_SHIFT;
            else
               target[s] = (32'(stg[s].cfg.tms) * 32'(stg[s].thr)) << INV_SHIFT;
            step[s] = 32'(mag[s]);
         end
         else
         begin
            target[s] = 32'(stg[s].delay);
            step[s]   = 32'h1;
         end
      end
   end

   // stage timers
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         run <= 6'h0;
         for (int s = 0; s < NSTG; s++)
         begin
            cnt[s]  <= 32'h0;
            hcnt[s] <= 16'h0;
         end
      end
      else
      begin
         for (int s = 0; s < NSTG; s++)
         begin
            if (over[s])
            begin
               hcnt[s] <= 16'h0;
               if (!BLOCK[s])
               begin
                  run[s] <= 1'b1;
                  if (tick && cnt[s] < target[s])
                     cnt[s] <= cnt[s] + step[s];
               end
            end
            else if (trip_q[s] || !RST_TIMER_MASK[s])
            begin
               cnt[s]  <= 32'h0;
               hcnt[s] <= 16'h0;
               run[s]  <= 1'b0;
            end
            else if (!under[s])
               hcnt[s] <= 16'h0;
            else if (ctrl[s < NPH ? CTRL_RT_PH : CTRL_RT_E] != RT_DEFINITE && eff_inv[s])
            begin
               if (tick)
                  cnt[s] <= (cnt[s] > 32'(stg[s].thr)) ? cnt[s] - 32'(stg[s].thr) : 32'h0;
               if (cnt[s] == 32'h0)
                  run[s] <= 1'b0;
            end
            else if (hcnt[s] >= stg[s].hold)
            begin
               cnt[s]  <= 32'h0;
               hcnt[s] <= 16'h0;
               run[s]  <= 1'b0;
            end
            else if (tick)
               hcnt[s] <= hcnt[s] + 16'h1;
         end
      end
   end

   // start and trip outputs
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         trip_q  <= 6'h0;
         start_q <= 6'h0;
      end
      else
         for (int s = 0; s < NSTG; s++)
         begin
            trip_q[s]  <= over[s] && !BLOCK[s] && run[s] && cnt[s] >= target[s];
            start_q[s] <= run[s];
         end
   end
   assign TRIP  = trip_q;
   assign START = start_q;

   // interrupt status, set wins over clear
   assign int_clr = (AVS_WRITE && AVS_ADDRESS == A_ICLR) ? AVS_WRITEDATA[11:0] : 12'h0;
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         ist <= 12'h0;
      else
         ist <= (ist & ~int_clr) | {run & ~start_q, trip_q & ~trip_prev};
   end
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         trip_prev <= 6'h0;
      else
         trip_prev <= trip_q;
   end
   assign IRQ = |(ist & ien);

   // register writes
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ctrl <= 2'h0;
         ien  <= 12'h0;
         for (int s = 0; s < NSTG; s++)
            stg[s] <= '0;
      end
      else if (AVS_WRITE)
      begin
         if (AVS_ADDRESS == A_IEN)
            ien <= AVS_WRITEDATA[11:0];
         if (AVS_ADDRESS == A_CTRL)
            ctrl <= AVS_WRITEDATA[1:0];
         for (int s = 0; s < NSTG; s++)
            if (AVS_ADDRESS[7:4] == 4'(s + 2))
               case (AVS_ADDRESS[3:2])
                  O_THR:   stg[s].thr   <= AVS_WRITEDATA[15:0];
                  O_DLY:   stg[s].delay <= AVS_WRITEDATA[15:0];
                  O_CFG:   stg[s].cfg   <= AVS_WRITEDATA[23:0];
                  default: stg[s].hold  <= AVS_WRITEDATA[15:0];
               endcase
      end
   end

   // register reads, one wait state
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rd_ack       <= 1'b0;
         AVS_READDATA <= 32'h0;
      end
      else
      begin
         rd_ack       <= AVS_READ && !rd_ack;
         AVS_READDATA <= 32'h0;
         if (AVS_READ && !rd_ack)
         begin
            if (AVS_ADDRESS == A_STAT)
               AVS_READDATA <= {20'h0, trip_q, start_q};
            else if (AVS_ADDRESS == A_IST)
               AVS_READDATA <= {20'h0, ist};
            else if (AVS_ADDRESS == A_IEN)
               AVS_READDATA <= {20'h0, ien};
            else if (AVS_ADDRESS == A_CTRL)
               AVS_READDATA <= {30'h0, ctrl};
            else if (AVS_ADDRESS >= A_STG && AVS_ADDRESS < A_STGEND)
               case (AVS_ADDRESS[3:2])
                  O_THR:   AVS_READDATA <= {16'h0, stg[AVS_ADDRESS[6:4] - 3'h2].thr};
                  O_DLY:   AVS_READDATA <= {16'h0, stg[AVS_ADDRESS[6:4] - 3'h2].delay};
                  O_CFG:   AVS_READDATA <= {8'h0, stg[AVS_ADDRESS[6:4] - 3'h2].cfg};
                  default: AVS_READDATA <= {16'h0, stg[AVS_ADDRESS[6:4] - 3'h2].hold};
               endcase
         end
      end
   end
   assign AVS_WAITREQUEST = AVS_READ && !rd_ack;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   generate
      for (genvar g = 0; g < NSTG; g++)
      begin : g_chk
         AST_FREEZE: assert property (over[g] && BLOCK[g] |=> cnt[g] == $past(cnt[g]))
            else $error("timer moved while blocked");
         AST_RESUME: assert property (over[g] && BLOCK[g] ##1 over[g] && !BLOCK[g]
            |=> cnt[g] >= $past(cnt[g], 2))
            else $error("count lost on release");
         AST_TRIP: assert property (trip_q[g] |-> $past(over[g] && !BLOCK[g] && run[g]))
            else $error("trip without its conditions");
         AST_START: assert property (over[g] && !BLOCK[g] |=> ##1 start_q[g])
            else $error("start late");
         AST_TRIPCLR: assert property (trip_q[g] && !over[g] |=> cnt[g] == 32'h0 && !run[g])
            else $error("tripped stage not reset");
         AST_STOPSTART: assert property (!run[g] |=> !start_q[g])
            else $error("start held after reset");
      end
   endgenerate
   AST_PHASE_OR: assert property (stg[0].cfg.psel == PSEL_ALL |->
      over[0] == (PHASE_A_MAG > stg[0].thr || PHASE_B_MAG > stg[0].thr
                  || PHASE_C_MAG > stg[0].thr))
      else $error("phase or wrong");
   AST_NO_INV3: assert property (eff_inv[2] == 1'b0 && eff_inv[4] == 1'b0
      && eff_inv[5] == 1'b0)
      else $error("inverse on definite stage");
   AST_QUICK_CLR: assert property (!over[2] && run[2] |=> !run[2])
      else $error("stage without reset timer held");
   COV_TRIP:  cover property (run[0] ##[1:8] trip_q[0]);
   COV_BLOCK: cover property (over[1] && BLOCK[1] ##1 over[1] && !BLOCK[1]);
   COV_HOLD:  cover property (!over[3] && under[3] && run[3] ##1 !run[3]);
endmodule // ocst_stages

// ==== design/ocst_pkg.sv ====
// package: constants, register map and types of the overcurrent stage timers
package ocst_pkg;
   localparam int CLK_HZ      = 125_000_000;
   localparam int TICK_MS     = 1;
   localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
   localparam int NSTG        = 6;
   localparam int NPH         = 3;
   localparam int PCT_NUM     = 19;
   localparam int PCT_DEN     = 20;
   localparam int INV_SHIFT   = 4;
   localparam logic [5:0] RST_TIMER_MASK = 6'h19;
   localparam logic [5:0] INV_OK_MASK    = 6'h0b;
   localparam logic [7:0] A_STAT   = 8'h00;
   localparam logic [7:0] A_IST    = 8'h04;
   localparam logic [7:0] A_ICLR   = 8'h08;
   localparam logic [7:0] A_IEN    = 8'h0c;
   localparam logic [7:0] A_CTRL   = 8'h10;
   localparam logic [7:0] A_STG    = 8'h20;
   localparam logic [7:0] A_STGEND = 8'h80;
   localparam logic [1:0] O_THR    = 2'h0;
   localparam logic [1:0] O_DLY    = 2'h1;
   localparam logic [1:0] O_CFG    = 2'h2;
   localparam logic [1:0] O_HOLD   = 2'h3;
   localparam int CTRL_RT_PH = 0;
   localparam int CTRL_RT_E  = 1;
   localparam logic RT_DEFINITE = 1'b0;
   localparam logic [1:0] PSEL_ALL = 2'h0;
   typedef enum logic [4:0] {
      CRV_IEC_SI = 5'h00, CRV_IEC_VI = 5'h01, CRV_IEC_EI = 5'h02, CRV_IEC_LTI = 5'h03,
      CRV_FR_STI = 5'h04, CRV_UK_RECT = 5'h05, CRV_IEEE_MI = 5'h06, CRV_IEEE_VI = 5'h07,
      CRV_IEEE_EI = 5'h08, CRV_CO2_P20 = 5'h09, CRV_CO2_P40 = 5'h0a, CRV_CO5 = 5'h0b,
      CRV_CO6 = 5'h0c, CRV_CO7 = 5'h0d, CRV_CO8 = 5'h0e, CRV_CO9 = 5'h0f,
      CRV_CO11 = 5'h10, CRV_RI = 5'h11, CRV_BNP = 5'h12, CRV_RXIDG = 5'h13
   } ocst_curve_t;
   typedef struct packed {
      logic [7:0]  time_dial_us;
      logic [7:0]  tms;
      ocst_curve_t curve;
      logic [1:0]  psel;
      logic        inverse_delay;
   } ocst_cfg_t;
   typedef struct packed {
      logic [15:0] thr;
      logic [15:0] delay;
      logic [15:0] hold;
      ocst_cfg_t   cfg;
   } ocst_stage_t;
endpackage

// ==== verif/ocst_front_model.sv ====
// partner model: current front end and downstream blocking relay
`timescale 1ns/100ps
module ocst_front_model
   import ocst_pkg::*;
(
   // clock
   input  wire logic        clk,
   // wanted currents and downstream fault view
   input  wire logic [15:0] want_a,
   input  wire logic [15:0] want_b,
   input  wire logic [15:0] want_c,
   input  wire logic [15:0] want_e,
   input  wire logic [5:0]  down_fault,
   // measured values towards the block
   output logic [15:0]      mag_a,
   output logic [15:0]      mag_b,
   output logic [15:0]      mag_c,
   output logic [15:0]      mag_e,
   output logic [5:0]       blk
);
   // magnitudes refresh once a clock
   always @(posedge clk)
   begin
      {mag_a, mag_b, mag_c, mag_e} <= {want_a, want_b, want_c, want_e};
   end
   always @(posedge clk)
   begin
      blk <= down_fault;
   end
endmodule // ocst_front_model

// ==== verif/ocst_stages_tb_top.sv ====
// testbench: stage timers against front end model
`timescale 1ns/100ps
module ocst_stages_tb_top
   import ocst_pkg::*;
;
   localparam int TK = 10;
   logic        clk, rst_n, avs_read, avs_write, irq, waitreq;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, readdata;
   logic [15:0] pa, pb, pc, pe, mag_a, mag_b, mag_c, mag_e;
   logic [5:0]  down, blk, start, trip;
   logic [31:0] rnd = 32'h1835b21f;
   logic [31:0] exp_q[$];
   int          num_errors = 0;
   int          samples_checked = 0;

   ocst_front_model fm_u (.clk(clk), .want_a(pa), .want_b(pb), .want_c(pc), .want_e(pe),
      .down_fault(down), .mag_a(mag_a), .mag_b(mag_b), .mag_c(mag_c), .mag_e(mag_e),
      .blk(blk));
   ocst_stages #(.TICK_CYCLES(TK)) dut_u (.SYS_CLK(clk), .RST_N(rst_n),
      .PHASE_A_MAG(mag_a), .PHASE_B_MAG(mag_b), .PHASE_C_MAG(mag_c), .EARTH_MAG(mag_e),
      .BLOCK(blk), .START(start), .TRIP(trip), .IRQ(irq), .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_READDATA(readdata), .AVS_WAITREQUEST(waitreq));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [7:0] sa(input int s, input logic [1:0] o);
      return A_STG + 8'(s * 16) + {4'h0, o, 2'b00};
   endfunction

   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= 1'b1;
      @(posedge clk iff !waitreq);
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      avs_address <= a;
      avs_read    <= 1'b1;
      @(posedge clk iff !waitreq);
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic stg(input int s, input logic [15:0] thr, input logic [15:0] dly,
                      input logic [31:0] cfg, input logic [15:0] hold);
      wr(sa(s, O_THR), {16'h0, thr});
      wr(sa(s, O_DLY), {16'h0, dly});
      wr(sa(s, O_CFG), cfg);
      wr(sa(s, O_HOLD), {16'h0, hold});
   endtask

   // read data compared when the slave answers
   always @(posedge clk)
   begin
      if (avs_read && !waitreq)
         chk("readdata", exp_q.pop_front(), readdata);
   end

   initial
   begin
      cyc(20000);
      num_errors++;
      test_done();
   end

   initial
   begin
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      {pa, pb, pc, pe, down} = '0;
      rst_n = 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(1);
      rd(A_STAT, 32'h0);
      rd(A_ICLR, 32'h0);
      rd(A_STGEND, 32'h0);
      rd(sa(4, O_THR), 32'h0);
      for (int s = 0; s < NSTG; s++)
         stg(s, 16'hffff, 16'h0, 32'h0, 16'h0);
      wr(A_IEN, 32'h40);
      stg(0, 16'd100, 16'd4, 32'h2, 16'd50);
      rnd = xs(rnd);
      pa <= 16'd50;
      pb <= 16'd200 + {8'h0, rnd[7:0]};
      pc <= 16'd300 + {8'h0, rnd[15:8]};
      cyc(30);
      chk("start", 32'h0, {26'h0, start});
      pa <= 16'd200 + {9'h0, rnd[22:16]};
      cyc(5);
      chk("start", 32'h1, {26'h0, start});
      chk("irq", 32'h1, {31'h0, irq});
      cyc(20);
      chk("trip", 32'h0, {26'h0, trip});
      down <= 6'h1;
      cyc(80);
      chk("trip", 32'h0, {26'h0, trip});
      down <= 6'h0;
      cyc(27);
      chk("trip", 32'h1, {26'h0, trip});
      pa <= 16'd0;
      cyc(5);
      chk("start", 32'h0, {26'h0, start});
      chk("trip", 32'h0, {26'h0, trip});
      rd(A_IST, 32'h41);
      wr(A_IEN, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      wr(A_IEN, 32'h1);
      chk("irq", 32'h1, {31'h0, irq});
      wr(A_ICLR, 32'h41);
      rd(A_IST, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      stg(1, 16'd100, 16'd0, 32'h0, 16'd0);
      stg(5, 16'd100, 16'd0, 32'h801, 16'd0);
      pb <= 16'd300;
      pc <= 16'd0;
      pe <= 16'd150 + {12'h0, rnd[27:24]};
      cyc(6);
      chk("trip", 32'h22, {26'h0, trip});
      rd(A_STAT, {20'h0, 6'h22, 6'h22});
      pb <= 16'd0;
      pe <= 16'd0;
      stg(5, 16'hffff, 16'd0, 32'h0, 16'd0);
      stg(3, 16'd100, 16'd5, 32'h0, 16'd3);
      pe <= 16'd200;
      cyc(25);
      pe <= 16'd90;
      cyc(12);
      chk("start", 32'h8, {26'h0, start});
      pe <= 16'd200;
      cyc(34);
      chk("trip", 32'h8, {26'h0, trip});
      pe <= 16'd0;
      cyc(5);
      test_done();
   end
endmodule // ocst_stages_tb_top
